/* shared/eeiu_pkg.sv */
// Purpose: shared constants and carriers for the edge interrupt unit
// Assumes: 8-bit register bus, one control register per unit
// Notes:   a channel field is a nibble: flag, select hi, select lo, enable
package eeiu_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned NUM_UNITS   = 3;
  localparam int unsigned CH_PER_UNIT = 2;
  localparam int unsigned NUM_CH      = NUM_UNITS * CH_PER_UNIT;
  localparam int unsigned CH_FIELD_W  = 4;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL_UNIT1 = 8'h49;
  localparam logic [ADDR_W-1:0] OFS_CTRL_UNIT2 = 8'h4a;
  localparam logic [ADDR_W-1:0] OFS_CTRL_UNIT3 = 8'h4b;
  localparam logic [ADDR_W-1:0] OFS_PORT_LEVEL = 8'h4c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h4d;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h4e;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h4f;

  // ----------------------------------------------------------------
  // field positions inside a channel nibble, reset values
  // ----------------------------------------------------------------
  localparam int unsigned FLD_ENABLE = 0;
  localparam int unsigned FLD_SEL_LO = 1;
  localparam int unsigned FLD_SEL_HI = 2;
  localparam int unsigned FLD_FLAG   = 3;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] FLAG_MASK  = 8'h88;
  localparam logic [NUM_CH-1:0] CH_RESET   = 6'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } eeiu_edge_sel_t;

  typedef struct packed {
    logic edge_flag_ch1;
    logic edge_select_ch1_hi;
    logic edge_select_ch1_lo;
    logic request_enable_ch1;
    logic edge_flag_ch0;
    logic edge_select_ch0_hi;
    logic edge_select_ch0_lo;
    logic request_enable_ch0;
  } eeiu_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic              rmw;
  } eeiu_bus_req_t;

endpackage

/* verilog/eeiu_unit.sv */
// Purpose: one unit: control register and two edge channels
// Assumes: pins synchronous to clk_i in timing only, sampled twice anyway
// Notes:   absent pins are masked to a constant low
`timescale 1ns/1ps
module eeiu_unit #(
  parameter logic [1:0] PIN_MASK = 2'h3
) (
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     wr_i,
  input  wire logic [7:0]               wdata_i,
  input  wire logic [1:0]               pin_i,
  input  wire logic [1:0]               pin_is_input_i,
  output eeiu_pkg::eeiu_ctrl_t          ctrl_o,
  output logic      [1:0]               edge_o,
  output logic      [1:0]               req_o
);

  typedef struct packed {
    eeiu_pkg::eeiu_ctrl_t ctrl;
    logic [1:0]           sync1;
    logic [1:0]           sync2;
    logic [1:0]           prev;
  } eeiu_unit_state_t;

  localparam eeiu_unit_state_t UNIT_RESET = '0;

  eeiu_unit_state_t q;
  eeiu_unit_state_t d;
  logic [7:0]       cur_v;
  logic [7:0]       nxt_v;
  logic [1:0]       hit;

  function automatic logic edge_match(
    input logic [1:0] sel,
    input logic       was,
    input logic       now
  );
    case (eeiu_pkg::eeiu_edge_sel_t'(sel))
      eeiu_pkg::EDGE_RISE: edge_match = !was && now;
      eeiu_pkg::EDGE_FALL: edge_match = was && !now;
      eeiu_pkg::EDGE_BOTH: edge_match = was ^ now;
      default:             edge_match = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d       = q;
    d.sync1 = pin_i & PIN_MASK;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    cur_v   = q.ctrl;
    nxt_v   = cur_v;
    hit     = 2'h0;
    req_o   = 2'h0;
    for (int c = 0; c < 2; c++)
    begin
      // flag only reacts while the pin is an input
      hit[c] = edge_match(cur_v[c*4+eeiu_pkg::FLD_SEL_LO +: 2],
                          q.prev[c], q.sync2[c])
               && pin_is_input_i[c] && PIN_MASK[c];
      if (wr_i)
      begin
        nxt_v[c*4+eeiu_pkg::FLD_ENABLE] = wdata_i[c*4+eeiu_pkg::FLD_ENABLE];
        nxt_v[c*4+eeiu_pkg::FLD_SEL_LO +: 2] =
          wdata_i[c*4+eeiu_pkg::FLD_SEL_LO +: 2];
        if (!wdata_i[c*4+eeiu_pkg::FLD_FLAG])
        begin
          nxt_v[c*4+eeiu_pkg::FLD_FLAG] = 1'b0;
        end
      end
      // set beats a same-cycle clear so no edge is lost
      if (hit[c])
      begin
        nxt_v[c*4+eeiu_pkg::FLD_FLAG] = 1'b1;
      end
      req_o[c] = cur_v[c*4+eeiu_pkg::FLD_FLAG]
                 && cur_v[c*4+eeiu_pkg::FLD_ENABLE]
                 && pin_is_input_i[c];
    end
    d.ctrl = nxt_v;
  end

  assign edge_o = hit;
  assign ctrl_o = q.ctrl;

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      q <= UNIT_RESET;
    end
    else
    begin
      q <= d;
    end
  end

endmodule

/* verilog/eeiu_top.sv */
// Purpose: edge interrupt block with three units and a register port
// Assumes: single-cycle strobes, read data valid the cycle after rd
// Notes:   reduced variant keeps units 2 and 3, one pin each
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module eeiu_top #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  input  eeiu_pkg::eeiu_bus_req_t     bus_i,
  output logic [7:0]                  rdata_o,
  input  wire logic [5:0]             pin_level_i,
  input  wire logic [5:0]             pin_is_input_i,
  output logic [5:0]                  irq_req_o,
  output logic                        irq_o,
  output logic                        wake_o
);

  // ----------------------------------------------------------------
  // variant shape
  // ----------------------------------------------------------------
  // the reduced part drops unit 1 and the second pin of units 2 and 3
  localparam logic [2:0] UNIT_PRESENT = FULL_VARIANT ? 3'h7 : 3'h6;
  localparam logic [1:0] PIN_MASK_LO  = FULL_VARIANT ? 2'h3 : 2'h0;
  localparam logic [1:0] PIN_MASK_HI  = FULL_VARIANT ? 2'h3 : 2'h1;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
    logic [5:0] status;
    logic [5:0] enable;
    logic [5:0] port_latch;
  } eeiu_top_state_t;

  localparam eeiu_top_state_t TOP_RESET = '{
    rdata:      eeiu_pkg::CTRL_RESET,
    status:     eeiu_pkg::CH_RESET,
    enable:     eeiu_pkg::CH_RESET,
    port_latch: eeiu_pkg::CH_RESET
  };

  eeiu_top_state_t      q;
  eeiu_top_state_t      d;
  eeiu_pkg::eeiu_ctrl_t ctrl_v [3];
  logic [5:0]           events;
  logic [5:0]           unit_req;
  logic [2:0]           unit_wr;
  logic [5:0]           port_view;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic is_ctrl_addr(
    input logic [7:0] addr,
    input int unsigned u
  );
    case (u)
      0:       is_ctrl_addr = addr == eeiu_pkg::OFS_CTRL_UNIT1;
      1:       is_ctrl_addr = addr == eeiu_pkg::OFS_CTRL_UNIT2;
      2:       is_ctrl_addr = addr == eeiu_pkg::OFS_CTRL_UNIT3;
      default: is_ctrl_addr = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // units
  // ----------------------------------------------------------------
  for (genvar u = 0; u < 3; u++)
  begin : g_unit
    assign unit_wr[u] = bus_i.wr && UNIT_PRESENT[u]
                        && is_ctrl_addr(bus_i.addr, u);

    eeiu_unit #(
      .PIN_MASK (u == 0 ? PIN_MASK_LO : PIN_MASK_HI)
    ) u_unit (
      .clk_i          (clk_i),
      .reset_n_i      (reset_n_i),
      .wr_i           (unit_wr[u]),
      .wdata_i        (bus_i.wdata),
      .pin_i          (pin_level_i[u*2 +: 2]),
      .pin_is_input_i (pin_is_input_i[u*2 +: 2]),
      .ctrl_o         (ctrl_v[u]),
      .edge_o         (events[u*2 +: 2]),
      .req_o          (unit_req[u*2 +: 2])
    );
  end

  // ----------------------------------------------------------------
  // port level view
  // ----------------------------------------------------------------
  // rmw reads see the stored value so a write-back cannot copy a live pin
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      port_view[i] = (pin_is_input_i[i] && !bus_i.rmw)
                     ? pin_level_i[i] : q.port_latch[i];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d       = q;
    d.rdata = 8'h00;

    // read side
    if (bus_i.rd)
    begin
      for (int u = 0; u < 3; u++)
      begin
        if (UNIT_PRESENT[u] && is_ctrl_addr(bus_i.addr, u))
        begin
          d.rdata = bus_i.rmw ? (ctrl_v[u] | eeiu_pkg::FLAG_MASK)
                              : ctrl_v[u];
        end
      end
      case (bus_i.addr)
        eeiu_pkg::OFS_PORT_LEVEL:
        begin
          d.rdata = {2'h0, port_view};
        end
        eeiu_pkg::OFS_IRQ_STATUS:
        begin
          d.rdata = {2'h0, q.status};
        end
        eeiu_pkg::OFS_IRQ_ENABLE:
        begin
          d.rdata = {2'h0, q.enable};
        end
        default:
        begin
          d.rdata = d.rdata;
        end
      endcase
    end

    // write side
    if (bus_i.wr)
    begin
      case (bus_i.addr)
        eeiu_pkg::OFS_PORT_LEVEL:
        begin
          d.port_latch = bus_i.wdata[5:0];
        end
        eeiu_pkg::OFS_IRQ_CLEAR:
        begin
          d.status = q.status & ~bus_i.wdata[5:0];
        end
        eeiu_pkg::OFS_IRQ_ENABLE:
        begin
          d.enable = bus_i.wdata[5:0];
        end
        default:
        begin
          d.status = q.status;
        end
      endcase
    end

    // a new edge wins over a clear in the same cycle
    d.status = d.status | events;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      q <= TOP_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o   = q.rdata;
  assign irq_req_o = unit_req;
  // wake is a plain level so it needs no clock to be seen in standby
  assign wake_o    = |unit_req;
  assign irq_o     = |(q.status & q.enable);

endmodule

/* testbench/eeiu_props.sv */
// Purpose: port checks for the edge interrupt block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every instance of the top module
`timescale 1ns/1ps
module eeiu_props (
  input wire logic               clk_i,
  input wire logic               reset_n_i,
  input eeiu_pkg::eeiu_bus_req_t bus_i,
  input wire logic [7:0]         rdata_o,
  input wire logic [5:0]         pin_level_i,
  input wire logic [5:0]         pin_is_input_i,
  input wire logic [5:0]         irq_req_o,
  input wire logic               irq_o,
  input wire logic               wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // only units 2 and 3 exist in both variants
  wire logic ctl = bus_i.addr == 8'h4a || bus_i.addr == 8'h4b;
  wire logic unm = bus_i.addr < 8'h49 || bus_i.addr > 8'h4f || bus_i.addr == 8'h4e;
  AST_WAKE: assert property (wake_o == |irq_req_o) else $error("wake not or of requests");
  AST_DIR: assert property ((irq_req_o & ~pin_is_input_i) == 6'h00) else $error("request on output pin");
  AST_RMW: assert property (bus_i.rd && bus_i.rmw && ctl |=> rdata_o[7] && rdata_o[3])
    else $error("rmw read of flags not one");
  AST_UNMAP: assert property (bus_i.rd && unm |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  AST_IDLE: assert property (!bus_i.rd |=> rdata_o == 8'h00) else $error("read data outside read");
  AST_BACK: assert property (bus_i.wr && ctl ##2 bus_i.rd && !bus_i.rmw && !$past(bus_i.wr)
    && bus_i.addr == $past(bus_i.addr, 2) |=> {rdata_o[6:4], rdata_o[2:0]}
    == {$past(bus_i.wdata[6:4], 3), $past(bus_i.wdata[2:0], 3)}) else $error("select or enable readback");
  AST_RST: assert property ($rose(reset_n_i) |-> irq_req_o == 6'h00 && !irq_o && rdata_o == 8'h00)
    else $error("outputs not clear after reset");
  // quiet pins and no writes: requests may not move
  AST_QUIET: assert property ((reset_n_i && !bus_i.wr && $stable(pin_level_i)
    && $stable(pin_is_input_i))[*6] |-> $stable(irq_req_o) && $stable(irq_o)) else $error("request without edge");
endmodule
bind eeiu_top eeiu_props i_eeiu_props (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .pin_level_i(pin_level_i), .pin_is_input_i(pin_is_input_i), .irq_req_o(irq_req_o), .irq_o(irq_o), .wake_o(wake_o));

/* testbench/eeiu_edge_src.sv */
// Purpose: external edge sources driving the interrupt pins
// Assumes: pins are plain logic levels, no pull
// Notes:   slow mode adds one cycle of pin delay
`timescale 1ns/1ps
module eeiu_edge_src (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic [5:0] target_i,
  output logic      [5:0] pin_o
);
  logic [5:0] stage_q;
  // pins stay unknown until the first edge; reset hides that from the design
  always_ff @(posedge clk_i)
  begin
    stage_q <= target_i;
    pin_o   <= slow_i ? stage_q : target_i;
  end
endmodule

/* testbench/tb.sv */
// Purpose: self-checking bench for the edge interrupt block
// Assumes: full and reduced variants share bus and pins
// Notes:   fixed waits follow the three-cycle edge path
`timescale 1ns/1ps
module tb;
  logic                    clk_i;
  logic                    reset_n_i;
  logic                    slow;
  eeiu_pkg::eeiu_bus_req_t bus;
  logic [7:0]              rdata;
  logic [7:0]              d;
  logic [5:0]              target;
  logic [5:0]              pins;
  logic [5:0]              dir;
  logic [5:0]              irq_req;
  logic [5:0]              irq_req_r;
  logic                    irq;
  logic                    wake;
  int                      mismatches;
  int                      checks_done;
  int                      seed;
  int                      sel;
  int                      ch;
  eeiu_top #(.FULL_VARIANT(1'b1)) i_eeiu_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus),
    .rdata_o(rdata), .pin_level_i(pins), .pin_is_input_i(dir), .irq_req_o(irq_req), .irq_o(irq), .wake_o(wake));
  eeiu_top #(.FULL_VARIANT(1'b0)) i_eeiu_top_reduced (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus),
    .rdata_o(), .pin_level_i(pins), .pin_is_input_i(dir), .irq_req_o(irq_req_r), .irq_o(), .wake_o());
  eeiu_edge_src i_eeiu_edge_src (.clk_i(clk_i), .slow_i(slow), .target_i(target), .pin_o(pins));
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [7:0] cv(int c, int s, logic en, logic fl);
    return (c % 2) ? {fl, 2'(s), en, 4'h0} : {4'h0, fl, 2'(s), en};
  endfunction
  function automatic logic [7:0] ad(int c);
    return eeiu_pkg::OFS_CTRL_UNIT1 + 8'(c / 2);
  endfunction
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0, rmw: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic xrd(string what, logic [7:0] a, logic m, logic [7:0] exp);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, rmw: m};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 check(what, exp, rdata);
  endtask
  task automatic edge_step(int c, int s, logic lvl, logic hit);
    wr(ad(c), cv(c, s, 1'b1, 1'b0));
    target[c] <= lvl;
    repeat (7) @(posedge clk_i);
    xrd("flag", ad(c), 1'b0, cv(c, s, 1'b1, hit));
    check("req", {7'h0, hit}, {7'h0, irq_req[c]});
    check("wake", {7'h0, hit}, {7'h0, wake});
    check("reduced req", {7'h0, hit && (c == 2 || c == 4)}, {7'h0, irq_req_r[c]});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    seed = 32'h9153a0bd;
    mismatches = 0;
    checks_done = 0;
    reset_n_i = 1'b0;
    slow = 1'b0;
    target = 6'h00;
    dir = 6'h3f;
    bus = '{default: '0};
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int a = 8'h48; a <= 8'h50; a++) xrd("reset", 8'(a), 1'b0, 8'h00);
    repeat (16)
    begin
      d = 8'($random(seed));
      ch = d % 6;
      wr(ad(ch), d);
      xrd("ctrl", ad(ch), 1'b0, d & 8'h77);
      xrd("ctrl rmw", ad(ch), 1'b1, d | 8'h88);
    end
    // modes walk every channel; a left-over enable would hold wake high
    for (sel = 0; sel < 4; sel++)
      for (ch = 0; ch < 6; ch++)
      begin
        slow <= 1'($random(seed));
        wr(ad(ch), cv(ch, sel, 1'b0, 1'b0));
        edge_step(ch, sel, 1'b1, sel[0]);
        edge_step(ch, sel, 1'b0, sel[1]);
        wr(ad(ch), 8'h00);
      end
    wr(eeiu_pkg::OFS_CTRL_UNIT1, 8'h03);
    dir[0] <= 1'b0;
    target[0] <= 1'b1;
    repeat (7) @(posedge clk_i);
    xrd("output pin", eeiu_pkg::OFS_CTRL_UNIT1, 1'b0, 8'h03);
    dir <= 6'h3f;
    target <= 6'($random(seed)) & 6'h3e;
    repeat (7) @(posedge clk_i);
    xrd("port live", eeiu_pkg::OFS_PORT_LEVEL, 1'b0, {2'b00, target});
    wr(eeiu_pkg::OFS_PORT_LEVEL, 8'h2a);
    xrd("port rmw", eeiu_pkg::OFS_PORT_LEVEL, 1'b1, 8'h2a);
    wr(eeiu_pkg::OFS_IRQ_CLEAR, 8'h3f);
    target[0] <= 1'b0;
    repeat (7) @(posedge clk_i);
    target[0] <= 1'b1;
    repeat (7) @(posedge clk_i);
    xrd("status", eeiu_pkg::OFS_IRQ_STATUS, 1'b0, 8'h01);
    check("irq masked", 8'h00, {7'h0, irq});
    wr(eeiu_pkg::OFS_IRQ_ENABLE, 8'h01);
    #1 check("irq on", 8'h01, {7'h0, irq});
    wr(eeiu_pkg::OFS_IRQ_CLEAR, 8'h01);
    #1 check("irq off", 8'h00, {7'h0, irq});
    xrd("clear reads", eeiu_pkg::OFS_IRQ_CLEAR, 1'b0, 8'h00);
    report_and_stop();
  end
endmodule
